/* src/itcd_params.svh */
// constants for the interrupt trigger select and clock detect register bank
// assumes a 100 MHz system clock and a byte-wide indexed register port
`ifndef ITCD_PARAMS_SVH
`define ITCD_PARAMS_SVH

// register indices on the configuration port
`define ITCD_OFS_STRAP 8'h3C
`define ITCD_OFS_TRIG_LOW 8'h3D
`define ITCD_OFS_TRIG_HIGH 8'h3E
`define ITCD_OFS_CLK_DET 8'h3F

// field positions
`define ITCD_SCHEME_BIT 5
`define ITCD_VALID_BIT 7
`define ITCD_STRAP_ALT_BIT 1

// reset values and the frequency saturation value
`define ITCD_TRIG_LOW_RST 8'h00
`define ITCD_TRIG_HIGH_RST 8'h00
`define ITCD_FREQ_RST 7'h00
`define ITCD_FREQ_SAT 7'h7F

// measurement gate: a 1000 ns window counts edges directly in MHz
`define ITCD_CLK_MHZ 100
`define ITCD_GATE_NS 1000
`define ITCD_GATE_CYC ((`ITCD_GATE_NS * `ITCD_CLK_MHZ) / 1000)

`endif

/* src/itcd_pkg.sv */
// types shared by the trigger select and clock detect register bank
// assumes itcd_params.svh supplies all numeric constants
package itcd_pkg;

    typedef logic [7:0] itcd_byte_t;
    typedef logic [6:0] itcd_freq_t;

    // measurement tracking: waiting for a first window, holding one
    // candidate, or locked onto a stable reading
    typedef enum logic [2:0] {
        MS_IDLE = 3'b001,
        MS_PEND = 3'b010,
        MS_LOCK = 3'b100
    } itcd_meas_e;

endpackage

/* src/itcd_clk_meter.sv */
// gated edge counter for the cpu bus clock
// assumes cpu_clk_i is sampled as a synchronous input; clocks above half
// the system rate alias and are not measured correctly
`timescale 1ns/100ps
`include "itcd_params.svh"

module itcd_clk_meter
    import itcd_pkg::*;
#(
    parameter int GATE_CYC = `ITCD_GATE_CYC
) (
    input wire logic clk_i,          // system clock
    input wire logic rst_n_i,        // synchronous reset, active low
    input wire logic cpu_clk_i,      // sampled cpu bus clock
    output itcd_freq_t count_o,      // edges in last window, MHz
    output logic done_o              // one-cycle pulse, window closed
);

    localparam int GW = $clog2(GATE_CYC + 1);

    logic prev_q;
    logic [GW-1:0] gate_q;
    itcd_freq_t edges_q;
    itcd_freq_t count_q;
    logic done_q;

    wire rise = cpu_clk_i & ~prev_q;
    wire gate_end = (gate_q == GW'(GATE_CYC - 1));
    // saturate rather than wrap so a fast clock never reads as slow
    wire at_sat = (edges_q == `ITCD_FREQ_SAT);
    wire itcd_freq_t edges_inc = at_sat ? edges_q : edges_q + 7'h01;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
            gate_q <= '0;
            edges_q <= `ITCD_FREQ_RST;
            count_q <= `ITCD_FREQ_RST;
            done_q <= 1'b0;
        end else begin
            prev_q <= cpu_clk_i;
            done_q <= gate_end;
            if (gate_end) begin
                gate_q <= '0;
                count_q <= rise ? edges_inc : edges_q;
                edges_q <= `ITCD_FREQ_RST;
            end else begin
                gate_q <= gate_q + GW'(1);
                if (rise) begin
                    edges_q <= edges_inc;
                end
            end
        end
    end

    assign count_o = count_q;
    assign done_o = done_q;

endmodule

/* src/itcd_regs.sv */
// interrupt trigger select and clock detect register bank
// Summary of operation
// - low register bits 7 and 6 pick edge or level for lines 0 and 1
// - low register bits 4 down to 0 pick edge or level for lines 3 to 7
// - low register bit 5 picks common sensing or the per-line selection
// - high register bits 7 down to 0 pick edge or level for lines 8 to 15
// - clock detect bit 7 flags the frequency field valid, zero after reset
// - clock detect bits 6 to 0 hold bus clock frequency in whole MHz
// - software writes never change the frequency field or valid flag
// - status bits 3, 2 and 0 show strap lines 3, 2 and 0
// - strap line 1 is caught at reset, shown in bit 1, picks pin function
// assumes a byte port: address, write data, write strobe, read strobe,
// read data in the cycle after the read strobe; inputs synchronous to clk_i
`timescale 1ns/100ps
`include "itcd_params.svh"

module itcd_regs
    import itcd_pkg::*;
#(
    parameter int GATE_CYC = `ITCD_GATE_CYC
) (
    input wire logic clk_i,              // system clock, 100 MHz
    input wire logic rst_n_i,            // synchronous reset, active low
    input wire logic [7:0] addr_i,       // register index
    input wire logic [7:0] wdata_i,      // write data
    input wire logic wr_i,               // write strobe, one cycle
    input wire logic rd_i,               // read strobe, one cycle
    output itcd_byte_t rdata_o,          // read data, cycle after rd_i
    input wire logic cpu_clk_i,          // cpu bus clock to measure
    input wire logic [3:0] strap_line_i, // mode strap lines 3..0
    input wire logic common_level_i,     // common level bit of peripheral core
    output logic [15:0] irq_level_o,     // 1 = line sensed by level
    output logic per_line_mode_o,        // 1 = per-line selection in force
    output logic alt_pin_func_o,         // latched strap line 1
    output itcd_freq_t freq_mhz_o,       // committed frequency
    output logic freq_valid_o            // committed valid flag
);

    // ---------------------------------------------------------------
    // decode of the byte port
    // ---------------------------------------------------------------
    wire hit_strap = (addr_i == `ITCD_OFS_STRAP);
    wire hit_low = (addr_i == `ITCD_OFS_TRIG_LOW);
    wire hit_high = (addr_i == `ITCD_OFS_TRIG_HIGH);
    wire hit_clk = (addr_i == `ITCD_OFS_CLK_DET);

    wire wr_low = wr_i & hit_low;
    wire wr_high = wr_i & hit_high;
    // writes to the clock detect or strap index are accepted and dropped
    wire wr_ignored = wr_i & (hit_clk | hit_strap);

    // ---------------------------------------------------------------
    // trigger select registers
    // ---------------------------------------------------------------
    itcd_byte_t trig_low_q;
    itcd_byte_t trig_high_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            trig_low_q <= `ITCD_TRIG_LOW_RST;
        end else if (wr_low) begin
            trig_low_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            trig_high_q <= `ITCD_TRIG_HIGH_RST;
        end else if (wr_high) begin
            trig_high_q <= wdata_i;
        end
    end

    wire scheme_sel = trig_low_q[`ITCD_SCHEME_BIT];

    // per-line select bit for line n; line 2 has no bit of its own and
    // reports the common setting so the cascade input is never split off
    function automatic logic line_sel(input itcd_byte_t lo,
                                      input itcd_byte_t hi,
                                      input int unsigned n,
                                      input logic common);
        logic r;
        r = common;
        if (n == 0) begin
            r = lo[7];
        end else if (n == 1) begin
            r = lo[6];
        end else if (n == 2) begin
            r = common;
        end else if (n <= 7) begin
            r = lo[7 - n];
        end else if (n <= 15) begin
            r = hi[15 - n];
        end
        return r;
    endfunction

    logic [15:0] level_d;

    // common mode: every line follows the peripheral core bit; per-line
    // mode: each line but line 2 follows its own select bit
    always_comb begin
        level_d = '0;
        for (int unsigned n = 0; n < 16; n++) begin
            if (scheme_sel) begin
                level_d[n] = line_sel(trig_low_q, trig_high_q, n,
                                      common_level_i);
            end else begin
                level_d[n] = common_level_i;
            end
        end
    end

    logic [15:0] irq_level_q;
    logic per_line_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_level_q <= '0;
            per_line_q <= 1'b0;
        end else begin
            irq_level_q <= level_d;
            per_line_q <= scheme_sel;
        end
    end

    // ---------------------------------------------------------------
    // strap lines
    // ---------------------------------------------------------------
    logic [3:0] strap_q;
    logic strap1_q;

    // strap line 1 is taken while reset is held, so the last sample before
    // release sticks; later movement of the pin is not seen
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            strap1_q <= strap_line_i[`ITCD_STRAP_ALT_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            strap_q <= 4'h0;
        end else begin
            strap_q <= strap_line_i;
        end
    end

    wire itcd_byte_t strap_view = {4'h0, strap_q[3], strap_q[2],
                                   strap1_q, strap_q[0]};

    // ---------------------------------------------------------------
    // clock measurement
    // ---------------------------------------------------------------
    itcd_freq_t meas_count;
    logic meas_done;

    itcd_clk_meter #(
        .GATE_CYC(GATE_CYC)
    ) u_meter (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .cpu_clk_i(cpu_clk_i),
        .count_o(meas_count),
        .done_o(meas_done)
    );

    // a reading is committed only once two windows in a row agree within
    // one count, which hides the +-1 edge jitter of an unaligned gate
    // at the cost of one extra window of latency after a change
    itcd_meas_e meas_state_q;
    itcd_meas_e meas_state_d;
    itcd_freq_t cand_q;
    itcd_freq_t cand_d;
    itcd_freq_t freq_q;
    itcd_freq_t freq_d;
    logic valid_q;
    logic valid_d;

    function automatic logic near_eq(input itcd_freq_t a,
                                     input itcd_freq_t b);
        logic [7:0] diff;
        diff = (a >= b) ? {1'b0, a} - {1'b0, b} : {1'b0, b} - {1'b0, a};
        return diff <= 8'h01;
    endfunction

    wire agree = near_eq(meas_count, cand_q);
    wire stable = near_eq(meas_count, freq_q);

    always_comb begin
        meas_state_d = meas_state_q;
        cand_d = cand_q;
        freq_d = freq_q;
        valid_d = valid_q;
        case (meas_state_q)
            MS_IDLE: begin
                if (meas_done) begin
                    cand_d = meas_count;
                    meas_state_d = MS_PEND;
                end
            end
            MS_PEND: begin
                if (meas_done) begin
                    if (agree) begin
                        freq_d = meas_count;
                        valid_d = (meas_count != `ITCD_FREQ_RST);
                        meas_state_d = MS_LOCK;
                    end
                    cand_d = meas_count;
                end
            end
            MS_LOCK: begin
                if (meas_done) begin
                    if (stable) begin
                        freq_d = meas_count;
                        valid_d = (meas_count != `ITCD_FREQ_RST);
                    end else begin
                        // clock moved: hold the old value until it settles
                        cand_d = meas_count;
                        meas_state_d = MS_PEND;
                    end
                end
            end
            default: begin
                meas_state_d = MS_IDLE;
                cand_d = `ITCD_FREQ_RST;
                freq_d = `ITCD_FREQ_RST;
                valid_d = 1'b0;
            end
        endcase
    end

    // no bus path reaches these registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meas_state_q <= MS_IDLE;
            cand_q <= `ITCD_FREQ_RST;
            freq_q <= `ITCD_FREQ_RST;
            valid_q <= 1'b0;
        end else begin
            meas_state_q <= meas_state_d;
            cand_q <= cand_d;
            freq_q <= freq_d;
            valid_q <= valid_d;
        end
    end

    wire itcd_byte_t clk_view = {valid_q, freq_q};

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    // unmapped indices read as zero; data stands for one cycle only
    itcd_byte_t rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (hit_low) begin
            rd_mux = trig_low_q;
        end else if (hit_high) begin
            rd_mux = trig_high_q;
        end else if (hit_clk) begin
            rd_mux = clk_view;
        end else if (hit_strap) begin
            rd_mux = strap_view;
        end
    end

    itcd_byte_t rdata_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (rd_i) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    logic alt_q;
    itcd_freq_t freq_out_q;
    logic valid_out_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alt_q <= 1'b0;
            freq_out_q <= `ITCD_FREQ_RST;
            valid_out_q <= 1'b0;
        end else begin
            alt_q <= strap1_q;
            freq_out_q <= freq_q;
            valid_out_q <= valid_q;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_level_o = irq_level_q;
    assign per_line_mode_o = per_line_q;
    assign alt_pin_func_o = alt_q;
    assign freq_mhz_o = freq_out_q;
    assign freq_valid_o = valid_out_q;

    // wr_ignored only documents the dropped accesses
    logic unused_ok;
    assign unused_ok = wr_ignored;

endmodule

/* sim/itcd_regs_sva.sv */
// checker for the trigger select and clock detect register bank
// assumes it sees only the top ports and is bound at the foot of this file
`timescale 1ns/100ps
module itcd_regs_sva
    import itcd_pkg::*;
(
    input wire logic clk_i,              // system clock
    input wire logic rst_n_i,            // reset, active low
    input wire logic [7:0] addr_i,       // register index
    input wire logic [7:0] wdata_i,      // write data
    input wire logic wr_i,               // write strobe
    input wire logic rd_i,               // read strobe
    input wire itcd_byte_t rdata_o,      // read data
    input wire logic [3:0] strap_line_i, // strap lines
    input wire logic common_level_i,     // common sensing bit
    input wire logic [15:0] irq_level_o, // per line sensing
    input wire logic per_line_mode_o,    // scheme in force
    input wire logic alt_pin_func_o,     // latched strap line 1
    input wire itcd_freq_t freq_mhz_o,   // committed frequency
    input wire logic freq_valid_o        // committed valid flag
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic [15:0] per_w;
    // shadow copies of the two select registers, kept from the bus alone
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lo_q <= 8'h00;
            hi_q <= 8'h00;
        end else if (wr_i && addr_i == 8'h3D) begin
            lo_q <= wdata_i;
        end else if (wr_i && addr_i == 8'h3E) begin
            hi_q <= wdata_i;
        end
    end
    assign per_w = {hi_q[0], hi_q[1], hi_q[2], hi_q[3], hi_q[4], hi_q[5], hi_q[6], hi_q[7],
        lo_q[0], lo_q[1], lo_q[2], lo_q[3], lo_q[4], common_level_i, lo_q[6], lo_q[7]};
    property p_per_line;
        $past(rst_n_i) && per_line_mode_o |-> irq_level_o == $past(per_w);
    endproperty
    a_per_line: assert property (p_per_line) else $error("per line sensing wrong");
    property p_common;
        $past(rst_n_i) && !per_line_mode_o |-> irq_level_o == {16{$past(common_level_i)}};
    endproperty
    a_common: assert property (p_common) else $error("common sensing wrong");
    property p_line2;
        $past(rst_n_i) |-> irq_level_o[2] == $past(common_level_i);
    endproperty
    a_line2: assert property (p_line2) else $error("line 2 sensing wrong");
    property p_mode;
        $past(rst_n_i) |-> per_line_mode_o == $past(lo_q[5]);
    endproperty
    a_mode: assert property (p_mode) else $error("scheme output wrong");
    property p_valid;
        freq_valid_o == (freq_mhz_o != 7'h00);
    endproperty
    a_valid: assert property (p_valid) else $error("valid flag wrong");
    property p_clk_rd;
        rd_i && addr_i == 8'h3F |=> rdata_o == {freq_valid_o, freq_mhz_o};
    endproperty
    a_clk_rd: assert property (p_clk_rd) else $error("clock detect read wrong");
    property p_alt;
        $past(rst_n_i, 2) |-> $stable(alt_pin_func_o);
    endproperty
    a_alt: assert property (p_alt) else $error("pin function moved");
    property p_strap;
        $past(rst_n_i) && rd_i && addr_i == 8'h3C |=> rdata_o == {4'h0,
            $past(strap_line_i[3:2], 2), $past(alt_pin_func_o), $past(strap_line_i[0], 2)};
    endproperty
    a_strap: assert property (p_strap) else $error("strap status read wrong");
    c_scheme: cover property (wr_i && addr_i == 8'h3D ##1 per_line_mode_o);
    c_valid: cover property ($rose(freq_valid_o));
    c_strap: cover property (rd_i && addr_i == 8'h3C);
endmodule

bind itcd_regs itcd_regs_sva u_sva (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .strap_line_i, .common_level_i, .irq_level_o, .per_line_mode_o,
    .alt_pin_func_o, .freq_mhz_o, .freq_valid_o);

/* sim/itcd_regs_tb_top.sv */
// self-checking bench for the trigger select and clock detect register bank
// assumes the design under src and the checker bound from its own file
`timescale 1ns/100ps
module itcd_regs_tb_top
    import itcd_pkg::*;
;
    // short gate keeps the run brief; a cpu period of 4 cycles gives GATE/4
    localparam int GATE = 20;
    localparam logic [7:0] LO [4] = '{8'h00, 8'hDF, 8'hA5, 8'h7A};
    localparam logic [7:0] HI [4] = '{8'hFF, 8'h81, 8'h3C, 8'hC3};
    logic clk_i, rst_n_i, wr_i, rd_i, cpu_clk_i, common_level_i, run;
    logic per_line_mode_o, alt_pin_func_o, freq_valid_o;
    logic [7:0] addr_i, wdata_i;
    logic [3:0] strap_line_i;
    logic [1:0] ph;
    logic [15:0] irq_level_o;
    itcd_byte_t rdata_o;
    itcd_freq_t freq_mhz_o;
    int n_errors, checks_done, cyc;
    itcd_regs #(.GATE_CYC(GATE)) dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .cpu_clk_i, .strap_line_i, .common_level_i, .irq_level_o,
        .per_line_mode_o, .alt_pin_func_o, .freq_mhz_o, .freq_valid_o);
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // cpu clock stands low whenever the measurement scenario is not running
    always @(posedge clk_i) begin
        ph <= run ? ph + 2'd1 : 2'd0;
        cpu_clk_i <= run & ph[1];
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk({8'h00, rdata_o}, {8'h00, e});
    endtask
    function automatic logic [15:0] f(input logic [7:0] l, input logic [7:0] h, input logic c);
        logic [15:0] e;
        e = {16{c}};
        if (l[5]) begin
            for (int i = 0; i < 8; i++) e[8 + i] = h[7 - i];
            for (int i = 0; i < 5; i++) e[3 + i] = l[4 - i];
            e[1] = l[6];
            e[0] = l[7];
        end
        return e;
    endfunction
    task automatic t_reset;
        rd_chk(8'h3D, 8'h00);
        rd_chk(8'h3E, 8'h00);
        rd_chk(8'h3F, 8'h00);
        chk({15'h0, alt_pin_func_o}, 16'h0001);
    endtask
    task automatic t_sel;
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 4; i++) begin
                common_level_i <= c[0];
                wr(8'h3D, LO[i]);
                wr(8'h3E, HI[i]);
                rd_chk(8'h3D, LO[i]);
                rd_chk(8'h3E, HI[i]);
                chk({15'h0, per_line_mode_o}, {15'h0, LO[i][5]});
                chk(irq_level_o, f(LO[i], HI[i], c[0]));
            end
        end
    endtask
    task automatic t_ro;
        wr(8'h3F, 8'hFF);
        wr(8'h3C, 8'hFF);
        wr(8'h41, 8'h00);
        rd_chk(8'h3F, 8'h00);
        rd_chk(8'h3C, 8'h02);
        rd_chk(8'h40, 8'h00);
        rd_chk(8'h3D, 8'h7A);
        strap_line_i <= 4'b1101;
        repeat (3) @(posedge clk_i);
        rd_chk(8'h3C, 8'h0F);
        chk({15'h0, alt_pin_func_o}, 16'h0001);
    endtask
    task automatic t_freq;
        run <= 1'b1;
        for (int k = 0; k < 400 && freq_valid_o !== 1'b1; k++) @(posedge clk_i);
        repeat (2 * GATE + 4) @(posedge clk_i);
        chk({9'h0, freq_mhz_o}, 16'(GATE / 4));
        wr(8'h3F, 8'h00);
        rd_chk(8'h3F, 8'h80 | 8'(GATE / 4));
        run <= 1'b0;
        for (int k = 0; k < 400 && freq_valid_o !== 1'b0; k++) @(posedge clk_i);
        rd_chk(8'h3F, 8'h00);
    endtask
    initial begin
        rst_n_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        run = 1'b0;
        ph = 2'd0;
        cpu_clk_i = 1'b0;
        common_level_i = 1'b0;
        strap_line_i = 4'b0010;
        n_errors = 0;
        checks_done = 0;
        cyc = 0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_sel();
        t_ro();
        t_freq();
        conclude();
    end
endmodule
